// ### bench/link_loop_model.sv
// Purpose: link partner, loops transmit words back into receive
// Assumes: one clock; a word moves when valid and ready
// Notes:   slow mode stalls every other cycle
`default_nettype none
module link_loop_model (
    // clock, reset and mode
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        slow,
    // link
    input  wire logic        tx_valid,
    input  wire logic [63:0] tx_word,
    input  wire logic        tx_ctl,
    output logic             tx_ready,
    output logic             rx_valid,
    output logic [63:0]      rx_word,
    output logic             rx_ctl
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tog_reg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) tog_reg <= 1'b0;
        else tog_reg <= ~tog_reg;
    end
    assign tx_ready = ~slow | tog_reg;
    assign rx_valid = tx_valid & tx_ready;
    // idle word inverted so stale data never matches
    assign rx_word = rx_valid ? tx_word : ~tx_word;
    assign rx_ctl = rx_valid & tx_ctl;
endmodule
`default_nettype wire

// ### bench/test_burst_port.sv
// Purpose: loopback bench of the burst user port
// Assumes: link model echoes transmit words into receive
// Notes:   ce and packet_mode each exercised by a scenario of their own
`default_nettype none
module test_burst_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, slow = 1'b0, tx_eob = 1'b0;
    logic ce = 1'b1, packet_mode = 1'b0;
    logic [burst_pkg::SYM_BITS-1:0] tx_words = '0, rx_words;
    logic [7:0] tx_count = '0, tx_chan = '0, rx_count, rx_chan;
    logic [3:0] tx_sob = '0, tx_sop = '0, tx_eopbits = '0;
    logic [3:0] rx_sob, rx_sop, rx_eopbits;
    logic rx_eob, tx_ready, lk_tx_valid, lk_tx_ctl, lk_tx_ready;
    logic lk_rx_valid, lk_rx_ctl;
    logic [63:0] lk_tx_word, lk_rx_word;
    int miscompares = 0, checks = 0;
    always #20 clk = ~clk;
    burst_port dut (.clk, .rst, .ce, .packet_mode, .tx_words,
        .tx_count, .tx_sob, .tx_eob, .tx_sop, .tx_eopbits, .tx_chan,
        .tx_ready, .lk_tx_valid, .lk_tx_word, .lk_tx_ctl, .lk_tx_ready,
        .lk_rx_valid, .lk_rx_word, .lk_rx_ctl, .rx_words, .rx_count,
        .rx_sob, .rx_eob, .rx_sop, .rx_eopbits, .rx_chan);
    link_loop_model lnk (.clk, .rst, .slow, .tx_valid(lk_tx_valid),
        .tx_word(lk_tx_word), .tx_ctl(lk_tx_ctl), .tx_ready(lk_tx_ready),
        .rx_valid(lk_rx_valid), .rx_word(lk_rx_word), .rx_ctl(lk_rx_ctl));
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic send(input logic [3:0] f, input logic [3:0] eop,
                        input logic [7:0] ch, input logic [3:0] n);
        int k;
        k = 0;
        while (tx_ready !== 1'b1 && k < 60) begin
            @(posedge clk);
            #1 k++;
        end
        for (int i = 0; i < 8; i++) tx_words[64*i+:64] = {ch, 56'(i)};
        {tx_sob, tx_eob, tx_sop} = {2'b00, f[3], 1'b0, f[2], 2'b00, f[1], 1'b0};
        {tx_eopbits, tx_chan, tx_count} = {eop, ch, n, 4'h0};
        @(posedge clk);
        #1 tx_count = '0;
    endtask
    task automatic expect_rx(input logic [3:0] f, input logic [3:0] eop,
                             input logic [7:0] ch, input logic [3:0] n);
        int k;
        k = 0;
        while (rx_count === 8'h00 && k < 60) begin
            @(posedge clk);
            #1 k++;
        end
        chk(rx_count, {56'h0, n, 4'h0});
        chk(rx_words[511:448], {ch, 56'h7});
        chk(rx_words[63:0], n == 4'h8 ? {ch, 56'h0} : 64'h0);
        chk({rx_sob, rx_eob, rx_sop, rx_eopbits},
            {2'b00, f[3], 1'b0, f[2], 2'b00, f[1], 1'b0, eop});
        if (f[3]) chk(rx_chan, ch);
        @(posedge clk);
        #1 chk(rx_count, 64'h0);
    endtask
    task automatic t_single;
        send(4'b1110, 4'hb, 8'h04, 4'h3);
        expect_rx(4'b1110, 4'hb, 8'h04, 4'h3);
        $display("single burst test done");
    endtask
    task automatic t_split;
        slow = 1'b1;
        send(4'b1010, 4'h0, 8'h02, 4'h8);
        send(4'b0100, 4'h0, 8'h02, 4'h8);
        expect_rx(4'b1010, 4'h0, 8'h02, 4'h8);
        expect_rx(4'b0100, 4'h0, 8'h02, 4'h8);
        send(4'b1110, 4'hb, 8'h05, 4'h2);
        expect_rx(4'b1110, 4'hb, 8'h05, 4'h2);
        send(4'b1100, 4'h0, 8'h02, 4'h8);
        expect_rx(4'b1100, 4'h0, 8'h02, 4'h8);
        slow = 1'b0;
        $display("split burst test done");
    endtask
    task automatic t_packet;
        packet_mode = 1'b1;
        send(4'b0010, 4'h0, 8'h06, 4'h8);
        send(4'b0000, 4'hb, 8'h06, 4'h3);
        expect_rx(4'b1010, 4'h0, 8'h06, 4'h8);
        expect_rx(4'b0100, 4'hb, 8'h06, 4'h3);
        packet_mode = 1'b0;
        $display("packet mode test done");
    endtask
    task automatic t_freeze;
        send(4'b1110, 4'hb, 8'h07, 4'h1);
        ce = 1'b0;
        repeat (5) begin
            @(posedge clk);
            #1 chk(tx_ready, 64'h0);
        end
        ce = 1'b1;
        expect_rx(4'b1110, 4'hb, 8'h07, 4'h1);
        $display("clock enable test done");
    endtask
    task automatic t_idle;
        send(4'b1110, 4'hb, 8'h03, 4'h0);
        repeat (12) begin
            @(posedge clk);
            #1 chk(rx_count, 64'h0);
        end
        chk(tx_ready, 64'h1);
        $display("idle test done");
    endtask
    task automatic summarize;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        #1 chk(tx_ready, 64'h1);
        rst = 1'b0;
        t_single;
        t_split;
        t_packet;
        t_freeze;
        t_idle;
        summarize;
    end
    initial begin
        #40000;
        miscompares++;
        summarize;
    end
endmodule
`default_nettype wire

// ### shared/burst_pkg.sv
// Purpose: shared constants of the channelized burst user port
// Assumes: single-segment interleaved framing, 64-bit words, 8-word symbols
// Notes:   link control word layout is local to this block
`default_nettype none
package burst_pkg;
    // ------------------------------------------------------------------
    // user symbol layout
    // ------------------------------------------------------------------
    localparam int WORD_W    = 64;
    localparam int SYM_WORDS = 8;
    localparam int SYM_BITS  = WORD_W * SYM_WORDS;
    localparam int SEG       = 1;
    localparam int CNT_HI    = 7;
    localparam int CNT_LO    = 4;
    localparam int EOP_FLAG  = 3;
    localparam logic [3:0] FULL_SYM = 4'h8;
    localparam logic [3:0] CNT_IDLE = 4'h0;
    localparam logic [3:0] EOP_NONE = 4'h0;
    // ------------------------------------------------------------------
    // link control word fields, channel sits in the low bits
    // ------------------------------------------------------------------
    localparam int CW_SOB    = 63;
    localparam int CW_EOB    = 62;
    localparam int CW_SOP    = 61;
    localparam int CW_EOP_HI = 60;
    localparam int CW_EOP_LO = 57;
    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [WORD_W-1:0]   WORD_RST = 64'h0;
    localparam logic [SYM_BITS-1:0] SYM_RST  = '0;
endpackage
`default_nettype wire

// ### shared/rx_sym_if.sv
// Purpose: receive symbol bundle from the regroup stage to the top
// Assumes: all members are registered by the source
// Notes:   count field meaningful in bits 7:4 only
`default_nettype none
interface rx_sym_if #(parameter int CHAN_W = 8);
    logic [burst_pkg::SYM_BITS-1:0] words;
    logic [7:0]                     count;
    logic [3:0]                     sob;
    logic                           eob;
    logic [3:0]                     sop;
    logic [3:0]                     eopbits;
    logic [CHAN_W-1:0]              chan;
    modport src (output words, count, sob, eob, sop, eopbits, chan);
    modport dst (input  words, count, sob, eob, sop, eopbits, chan);
endinterface
`default_nettype wire

// ### verilog/burst_port.sv
// Purpose: user transmit and receive burst ports, single segment
// Assumes: link side is a 64-bit word stream with a control flag
// Notes:   transmit takes one symbol at a time; tx_ready is the stall
`default_nettype none
// How it works
// - zero word count means idle cycle
// - single cycle burst has sob and eob
// - control words inserted at burst marks
// - receive may deliver interleaved bursts
// - receive flags bursts using sob bit1 only
// - receive uses same eop code format
// - receive data msb aligned, first word top
// - only single segment controls are meaningful
// - transmit inserts control words before downstream
// - receive strips control words into flags
// - both interleaved and packet modes supported
// - each word position holds 64 bits
// - eop flag high only at packet end
module burst_port #(
    parameter int CHAN_W = 8
) (
    // clock, reset, enable, mode
    input  wire logic                            clk,
    input  wire logic                            rst,
    input  wire logic                            ce,
    input  wire logic                            packet_mode,
    // user transmit symbol
    input  wire logic [burst_pkg::SYM_BITS-1:0]  tx_words,
    input  wire logic [7:0]                      tx_count,
    input  wire logic [3:0]                      tx_sob,
    input  wire logic                            tx_eob,
    input  wire logic [3:0]                      tx_sop,
    input  wire logic [3:0]                      tx_eopbits,
    input  wire logic [CHAN_W-1:0]               tx_chan,
    output logic                                 tx_ready,
    // link transmit words
    output logic                                 lk_tx_valid,
    output logic [burst_pkg::WORD_W-1:0]         lk_tx_word,
    output logic                                 lk_tx_ctl,
    input  wire logic                            lk_tx_ready,
    // link receive words
    input  wire logic                            lk_rx_valid,
    input  wire logic [burst_pkg::WORD_W-1:0]    lk_rx_word,
    input  wire logic                            lk_rx_ctl,
    // user receive symbol
    output logic [burst_pkg::SYM_BITS-1:0]       rx_words,
    output logic [7:0]                           rx_count,
    output logic [3:0]                           rx_sob,
    output logic                                 rx_eob,
    output logic [3:0]                           rx_sop,
    output logic [3:0]                           rx_eopbits,
    output logic [CHAN_W-1:0]                    rx_chan
);
    typedef enum logic [1:0] {
        tx_idle  = 2'b00,
        tx_start = 2'b01,
        tx_data  = 2'b11,
        tx_end   = 2'b10
    } tx_state_e;

    tx_state_e                      state_reg, state_next;
    logic [burst_pkg::SYM_BITS-1:0] sym_reg, sym_next;
    logic [3:0]                     n_reg, n_next;
    logic [3:0]                     idx_reg, idx_next;
    logic                           sop_reg, sop_next;
    logic                           eob_reg, eob_next;
    logic [3:0]                     eop_reg, eop_next;
    logic [CHAN_W-1:0]              chan_reg, chan_next;
    logic                           ov_reg, ov_next;
    logic                           oc_reg, oc_next;
    logic [burst_pkg::WORD_W-1:0]   ow_reg, ow_next;
    logic                           take;
    logic                           load;
    logic                           sob_in;
    logic                           eob_in;
    logic [2:0]                     pos;
    logic [burst_pkg::WORD_W-1:0]   top_word;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // counts above eight are clamped so a bad count cannot overrun
    function automatic logic [3:0] sym_words(input logic [7:0] cnt);
        logic [3:0] w;
        w = cnt[burst_pkg::CNT_HI:burst_pkg::CNT_LO];
        return (w > burst_pkg::FULL_SYM) ? burst_pkg::FULL_SYM : w;
    endfunction

    function automatic logic [burst_pkg::WORD_W-1:0] ctl_word(
        input logic              sob,
        input logic              eob,
        input logic              sop,
        input logic [3:0]        eop,
        input logic [CHAN_W-1:0] ch
    );
        logic [burst_pkg::WORD_W-1:0] w;
        w = burst_pkg::WORD_RST;
        w[burst_pkg::CW_SOB] = sob;
        w[burst_pkg::CW_EOB] = eob;
        w[burst_pkg::CW_SOP] = sop;
        w[burst_pkg::CW_EOP_HI:burst_pkg::CW_EOP_LO] = eop;
        w[CHAN_W-1:0] = ch;
        return w;
    endfunction

    // ------------------------------------------------------------------
    // transmit: take symbol, insert control words, serialize
    // ------------------------------------------------------------------
    assign tx_ready = (state_reg == tx_idle);
    assign load     = !ov_reg || lk_tx_ready;
    assign take     = tx_ready && (sym_words(tx_count) != 4'h0);
    // packet mode frames one burst per packet from sop and eop
    assign sob_in   = packet_mode ? tx_sop[burst_pkg::SEG]
                                  : tx_sob[burst_pkg::SEG];
    assign eob_in   = packet_mode ? tx_eopbits[burst_pkg::EOP_FLAG]
                                  : tx_eob;
    assign pos      = 3'(burst_pkg::SYM_WORDS - 1) - idx_reg[2:0];
    assign top_word = sym_reg[burst_pkg::SYM_BITS-1 -: burst_pkg::WORD_W];

    always_comb begin
        state_next = state_reg;
        sym_next   = sym_reg;
        n_next     = n_reg;
        idx_next   = idx_reg;
        sop_next   = sop_reg;
        eob_next   = eob_reg;
        eop_next   = eop_reg;
        chan_next  = chan_reg;
        ov_next    = ov_reg && !lk_tx_ready;
        oc_next    = oc_reg;
        ow_next    = ow_reg;
        case (state_reg)
            tx_idle: begin
                if (take) begin
                    sym_next   = tx_words;
                    n_next     = sym_words(tx_count);
                    idx_next   = 4'h0;
                    sop_next   = tx_sop[burst_pkg::SEG];
                    eob_next   = eob_in;
                    eop_next   = tx_eopbits;
                    chan_next  = tx_chan;
                    state_next = sob_in ? tx_start : tx_data;
                end
            end
            tx_start: begin
                if (load) begin
                    ov_next    = 1'b1;
                    oc_next    = 1'b1;
                    ow_next    = ctl_word(1'b1, 1'b0, sop_reg,
                                          burst_pkg::EOP_NONE,
                                          chan_reg);
                    state_next = tx_data;
                end
            end
            tx_data: begin
                if (load) begin
                    ov_next  = 1'b1;
                    oc_next  = 1'b0;
                    // most significant word leaves first
                    ow_next  = sym_reg[pos*burst_pkg::WORD_W +:
                                       burst_pkg::WORD_W];
                    idx_next = idx_reg + 4'h1;
                    if (idx_reg + 4'h1 == n_reg) begin
                        state_next = eob_reg ? tx_end : tx_idle;
                    end
                end
            end
            tx_end: begin
                if (load) begin
                    ov_next    = 1'b1;
                    oc_next    = 1'b1;
                    ow_next    = ctl_word(1'b0, 1'b1, 1'b0, eop_reg,
                                          '0);
                    state_next = tx_idle;
                end
            end
            default: begin
                state_next = tx_idle;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= tx_idle;
            sym_reg   <= burst_pkg::SYM_RST;
            n_reg     <= burst_pkg::CNT_IDLE;
            idx_reg   <= 4'h0;
            sop_reg   <= 1'b0;
            eob_reg   <= 1'b0;
            eop_reg   <= burst_pkg::EOP_NONE;
            chan_reg  <= '0;
            ov_reg    <= 1'b0;
            oc_reg    <= 1'b0;
            ow_reg    <= burst_pkg::WORD_RST;
        end else if (ce) begin
            state_reg <= state_next;
            sym_reg   <= sym_next;
            n_reg     <= n_next;
            idx_reg   <= idx_next;
            sop_reg   <= sop_next;
            eob_reg   <= eob_next;
            eop_reg   <= eop_next;
            chan_reg  <= chan_next;
            ov_reg    <= ov_next;
            oc_reg    <= oc_next;
            ow_reg    <= ow_next;
        end
    end

    assign lk_tx_valid = ov_reg;
    assign lk_tx_ctl   = oc_reg;
    assign lk_tx_word  = ow_reg;

    // ------------------------------------------------------------------
    // receive: regroup stage drives the user symbol
    // ------------------------------------------------------------------
    rx_sym_if #(.CHAN_W(CHAN_W)) rx_sym ();

    rx_regroup #(.CHAN_W(CHAN_W)) u_rx (
        .clk         (clk),
        .rst         (rst),
        .ce          (ce),
        .lk_rx_valid (lk_rx_valid),
        .lk_rx_word  (lk_rx_word),
        .lk_rx_ctl   (lk_rx_ctl),
        .sym         (rx_sym.src)
    );

    assign rx_words   = rx_sym.words;
    assign rx_count   = rx_sym.count;
    assign rx_sob     = rx_sym.sob;
    assign rx_eob     = rx_sym.eob;
    assign rx_sop     = rx_sym.sop;
    assign rx_eopbits = rx_sym.eopbits;
    assign rx_chan    = rx_sym.chan;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_idle_ignored;
        @(posedge clk) disable iff (rst)
        ce && tx_ready && tx_count[7:4] == 4'h0 |=> state_reg == tx_idle;
    endproperty
    a_idle_ignored: assert property (p_idle_ignored)
        else $error("idle transmit cycle was taken");
    property p_start_ctl;
        @(posedge clk) disable iff (rst)
        ce && take && sob_in
        ##1 (ce && load)[*1]
        |=> ov_reg && oc_reg && ow_reg[burst_pkg::CW_SOB]
            && ow_reg[CHAN_W-1:0] == chan_reg;
    endproperty
    a_start_ctl: assert property (p_start_ctl)
        else $error("burst start control word missing");
    property p_end_ctl;
        @(posedge clk) disable iff (rst)
        ce && state_reg == tx_end && load
        |=> oc_reg && ow_reg[burst_pkg::CW_EOB]
            && ow_reg[burst_pkg::CW_EOP_HI:burst_pkg::CW_EOP_LO]
               == $past(eop_reg) && state_reg == tx_idle;
    endproperty
    a_end_ctl: assert property (p_end_ctl)
        else $error("burst end control word wrong");
    property p_top_first;
        @(posedge clk) disable iff (rst)
        ce && state_reg == tx_data && load && idx_reg == 4'h0
        |=> !oc_reg && ow_reg == $past(top_word);
    endproperty
    a_top_first: assert property (p_top_first)
        else $error("first data word not the top word");
    property p_freeze;
        @(posedge clk) disable iff (rst)
        !ce |=> $stable(state_reg) && $stable(ov_reg) && $stable(idx_reg);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved while clock enable low");
    c_single_burst: cover property (@(posedge clk) disable iff (rst)
        ce && take && tx_sob[1] && tx_eob);
    c_tx_end: cover property (@(posedge clk) disable iff (rst)
        ce && state_reg == tx_end && load);
endmodule
`default_nettype wire

// ### verilog/rx_regroup.sv
// Purpose: strip link control words and regroup data into user symbols
// Assumes: link words arrive on clk, one per cycle when valid
// Notes:   a full symbol waits for the next link word to learn its eob
`default_nettype none
module rx_regroup #(
    parameter int CHAN_W = 8
) (
    // clock, reset and enable
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic                          ce,
    // link receive words
    input  wire logic                          lk_rx_valid,
    input  wire logic [burst_pkg::WORD_W-1:0]  lk_rx_word,
    input  wire logic                          lk_rx_ctl,
    // user symbol out
    rx_sym_if.src                              sym
);
    logic [burst_pkg::SYM_BITS-1:0] buf_reg, buf_next;
    logic [3:0]                     n_reg, n_next;
    logic                           act_reg, act_next;
    logic                           first_reg, first_next;
    logic                           sop_reg, sop_next;
    logic [CHAN_W-1:0]              chan_reg, chan_next;
    logic [burst_pkg::SYM_BITS-1:0] ow_reg, ow_next;
    logic [7:0]                     oc_reg, oc_next;
    logic [3:0]                     osob_reg, osob_next;
    logic                           oeob_reg, oeob_next;
    logic [3:0]                     osop_reg, osop_next;
    logic [3:0]                     oeop_reg, oeop_next;
    logic [CHAN_W-1:0]              ochan_reg, ochan_next;
    logic                           emit;
    logic                           eob_hit;
    logic [2:0]                     pos;

    // ------------------------------------------------------------------
    // strip and regroup
    // ------------------------------------------------------------------
    always_comb begin
        buf_next   = buf_reg;
        n_next     = n_reg;
        act_next   = act_reg;
        first_next = first_reg;
        sop_next   = sop_reg;
        chan_next  = chan_reg;
        ow_next    = ow_reg;
        ochan_next = ochan_reg;
        oc_next    = 8'h00;
        osob_next  = 4'h0;
        osop_next  = 4'h0;
        oeob_next  = 1'b0;
        oeop_next  = burst_pkg::EOP_NONE;
        emit       = 1'b0;
        eob_hit    = 1'b0;
        pos        = 3'(burst_pkg::SYM_WORDS - 1) - n_reg[2:0];
        if (lk_rx_valid && lk_rx_ctl) begin
            // control words never reach the user bus
            if (lk_rx_word[burst_pkg::CW_EOB] && act_reg) begin
                emit     = (n_reg != burst_pkg::CNT_IDLE);
                eob_hit  = 1'b1;
                act_next = 1'b0;
                n_next   = burst_pkg::CNT_IDLE;
            end
            if (lk_rx_word[burst_pkg::CW_SOB]) begin
                act_next   = 1'b1;
                first_next = 1'b1;
                sop_next   = lk_rx_word[burst_pkg::CW_SOP];
                chan_next  = lk_rx_word[CHAN_W-1:0];
                n_next     = burst_pkg::CNT_IDLE;
                buf_next   = burst_pkg::SYM_RST;
            end
        end else if (lk_rx_valid && act_reg) begin
            if (n_reg == burst_pkg::FULL_SYM) begin
                emit     = 1'b1;
                buf_next = burst_pkg::SYM_RST;
                buf_next[burst_pkg::SYM_BITS-1 -: burst_pkg::WORD_W] =
                    lk_rx_word;
                n_next   = 4'h1;
            end else begin
                buf_next[pos*burst_pkg::WORD_W +: burst_pkg::WORD_W] =
                    lk_rx_word;
                n_next   = n_reg + 4'h1;
            end
        end
        if (emit) begin
            ow_next  = buf_reg;
            oc_next  = {n_reg, 4'h0};
            osob_next[burst_pkg::SEG] = first_reg;
            osop_next[burst_pkg::SEG] = first_reg & sop_reg;
            oeob_next  = eob_hit;
            ochan_next = chan_reg;
            if (eob_hit) begin
                oeop_next = lk_rx_word[burst_pkg::CW_EOP_HI:
                                       burst_pkg::CW_EOP_LO];
            end
            // a start control in the same word sets it again above
            if (!(lk_rx_ctl && lk_rx_word[burst_pkg::CW_SOB])) begin
                first_next = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            buf_reg   <= burst_pkg::SYM_RST;
            n_reg     <= burst_pkg::CNT_IDLE;
            act_reg   <= 1'b0;
            first_reg <= 1'b0;
            sop_reg   <= 1'b0;
            chan_reg  <= '0;
            ow_reg    <= burst_pkg::SYM_RST;
            oc_reg    <= 8'h00;
            osob_reg  <= 4'h0;
            oeob_reg  <= 1'b0;
            osop_reg  <= 4'h0;
            oeop_reg  <= burst_pkg::EOP_NONE;
            ochan_reg <= '0;
        end else if (ce) begin
            buf_reg   <= buf_next;
            n_reg     <= n_next;
            act_reg   <= act_next;
            first_reg <= first_next;
            sop_reg   <= sop_next;
            chan_reg  <= chan_next;
            ow_reg    <= ow_next;
            oc_reg    <= oc_next;
            osob_reg  <= osob_next;
            oeob_reg  <= oeob_next;
            osop_reg  <= osop_next;
            oeop_reg  <= oeop_next;
            ochan_reg <= ochan_next;
        end
    end

    assign sym.words   = ow_reg;
    assign sym.count   = oc_reg;
    assign sym.sob     = osob_reg;
    assign sym.eob     = oeob_reg;
    assign sym.sop     = osop_reg;
    assign sym.eopbits = oeop_reg;
    assign sym.chan    = ochan_reg;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_rx_eop_at_end;
        @(posedge clk) disable iff (rst)
        oeop_reg[burst_pkg::EOP_FLAG] |-> oeob_reg && oc_reg[7:4] != 4'h0;
    endproperty
    a_rx_eop_at_end: assert property (p_rx_eop_at_end)
        else $error("rx eop flag outside a burst end");
    property p_rx_seg_only;
        @(posedge clk) disable iff (rst)
        osob_reg[3:2] == 2'b00 && !osob_reg[0] && osop_reg[3:2] == 2'b00
        && !osop_reg[0] && (!osop_reg[1] || osob_reg[1]);
    endproperty
    a_rx_seg_only: assert property (p_rx_seg_only)
        else $error("rx start flags outside segment one");
    property p_rx_end_ctl;
        @(posedge clk) disable iff (rst)
        ce && lk_rx_valid && lk_rx_ctl && lk_rx_word[burst_pkg::CW_EOB]
        && act_reg && n_reg != 4'h0
        |=> oeob_reg && oc_reg[7:4] == $past(n_reg);
    endproperty
    a_rx_end_ctl: assert property (p_rx_end_ctl)
        else $error("rx end control did not close the symbol");
    property p_rx_idle_count;
        @(posedge clk) disable iff (rst)
        ce && !lk_rx_valid |=> oc_reg == 8'h00 && !oeob_reg && !osob_reg[1];
    endproperty
    a_rx_idle_count: assert property (p_rx_idle_count)
        else $error("rx symbol without link input");
    c_rx_eop: cover property (@(posedge clk) disable iff (rst)
        oeop_reg[burst_pkg::EOP_FLAG]);
    c_rx_full: cover property (@(posedge clk) disable iff (rst)
        oc_reg[7:4] == burst_pkg::FULL_SYM && !oeob_reg);
endmodule
`default_nettype wire
